// file: pie_map.svh
// constants for the priority interrupt expander
`ifndef PIE_MAP_SVH
`define PIE_MAP_SVH
`define CLK_PERIOD_NS   20
`define SCAN_PERIOD_NS  900
`define SCAN_CYCLES     (`SCAN_PERIOD_NS / `CLK_PERIOD_NS)
`define NUM_LINES       8
`define EBUS_W          16
`define DEV_HI          3'h4
`define DEV_LO_LSB      0
`define DEV_HI_LSB      3
`define FUNC_LSB        6
`define OP_LSB          9
`define OP_EXC          3'h0
`define OP_OUT          3'h3
`define FN_CLEAR        3'h1
`define FN_ENABLE       3'h2
`define FN_CLR_EN       3'h3
`define FN_DISABLE      3'h4
`define FN_CLR_DIS      3'h5
`define VEC_TOP         1'h1
`define LINES_ZERO      8'h00
`endif

// file: pie_pkg.sv
// types for the priority interrupt expander
package pie_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_REQ  = 2'h1,
        ST_ACK  = 2'h3
    } req_state_t;

    typedef struct packed {
        logic       hit;
        logic [2:0] op;
        logic [2:0] func;
    } bus_cmd_t;

    typedef struct packed {
        logic clear;
        logic enable;
        logic disarm;
        logic load;
    } ctl_act_t;
endpackage

// file: priority_interrupt_expander.sv
// eight line priority interrupt expander, device side
`timescale 1ns/1ns
`include "pie_map.svh"

// Operation
// RULE_01 - eight lines, fixed priority by wiring
// RULE_02 - line, sync and mask registers
// RULE_03 - sample all lines every 900 ns
// RULE_04 - serve highest unmasked pending line first
// RULE_05 - lower requests stay latched until served
// RULE_06 - set mask bit blocks its line
// RULE_07 - mask changes only by software write
// RULE_08 - two locations per line, sixteen total
// RULE_09 - vectors lie in octal 0100..0177
// RULE_10 - vector holds one non-I/O instruction
// RULE_11 - jump-and-mark disables until re-enabled
// RULE_12 - CPU withholds ack around I/O, two-word
// RULE_13 - CPU withholds ack during shifts
// RULE_14 - CPU withholds ack during halt, step
// RULE_15 - codes 1,2,3: clear, enable, both
// RULE_16 - codes 4,5: disable, clear and disable
// RULE_17 - answer only device address 04X
// RULE_18 - request right follows chain position
// RULE_19 - request on trailing timing clock edge
// RULE_20 - drive vector on ack, release after
// RULE_21 - mask bit 0 is top priority line
// RULE_22 - request set forces chain out false
// RULE_23 - enable flag gates requests
// RULE_24 - reset idles logic, keeps mask
module priority_interrupt_expander #(
    parameter int NUM_LINES = `NUM_LINES,
    parameter int SCAN_CYC  = `SCAN_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [NUM_LINES-1:0] periph_line_i,
    input  wire logic                 interrupt_timing_clock_i,
    input  wire logic                 cpu_interrupt_acknowledge_i,
    input  wire logic                 jump_mark_inhibit_i,
    input  wire logic                 chain_priority_in_i,
    input  wire logic                 function_ready_i,
    input  wire logic                 data_ready_i,
    input  wire logic [`EBUS_W-1:0]   ebus_i,
    input  wire logic [2:0]           dev_addr_strap_i,
    input  wire logic [1:0]           vector_base_i,
    output logic                      cpu_interrupt_request_o,
    output logic                      chain_priority_out_o,
    output logic [`EBUS_W-1:0]        ebus_o,
    output logic                      ebus_oe_o
);

    // two-stage synchronisers for every pin
    logic [NUM_LINES-1:0] line_meta;
    logic [NUM_LINES-1:0] line_sync;
    logic [4:0]           ctl_meta;
    logic [4:0]           ctl_sync;
    logic [4:0]           ctl_prev;
    logic [`EBUS_W-1:0]   ebus_meta;
    logic [`EBUS_W-1:0]   ebus_sync;
    logic                 chain_meta;
    logic                 chain_sync;
    logic [4:0]           strap_meta;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_meta  <= `LINES_ZERO;
            line_sync  <= `LINES_ZERO;
            ctl_meta   <= 5'h00;
            ctl_sync   <= 5'h00;
            ctl_prev   <= 5'h00;
            ebus_meta  <= 16'h0000;
            ebus_sync  <= 16'h0000;
            chain_meta <= 1'b0;
            chain_sync <= 1'b0;
            strap_meta <= 5'h00;
        end else begin
            line_meta  <= periph_line_i;
            line_sync  <= line_meta;
            ctl_meta   <= {interrupt_timing_clock_i,
                           cpu_interrupt_acknowledge_i,
                           jump_mark_inhibit_i,
                           function_ready_i,
                           data_ready_i};
            ctl_sync   <= ctl_meta;
            ctl_prev   <= ctl_sync;
            ebus_meta  <= ebus_i;
            ebus_sync  <= ebus_meta;
            chain_meta <= chain_priority_in_i;
            chain_sync <= chain_meta;
            strap_meta <= {vector_base_i, dev_addr_strap_i};
        end
    end

    logic tclk_fall;
    logic ack_lvl;
    logic ack_rise;
    logic ack_fall;
    logic jmp_rise;
    logic fry_rise;
    logic dry_rise;
    assign tclk_fall = ctl_prev[4] & ~ctl_sync[4];
    assign ack_lvl   = ctl_sync[3];
    assign ack_rise  = ctl_sync[3] & ~ctl_prev[3];
    assign ack_fall  = ctl_prev[3] & ~ctl_sync[3];
    assign jmp_rise  = ctl_sync[2] & ~ctl_prev[2];
    assign fry_rise  = ctl_sync[1] & ~ctl_prev[1];
    assign dry_rise  = ctl_sync[0] & ~ctl_prev[0];

    // straps: second synchroniser stage, steady from then on
    logic [2:0] dev_lo;
    logic [1:0] vec_base;
    logic       strap_done;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_lo     <= 3'h0;
            vec_base   <= 2'h0;
            strap_done <= 1'b0;
        end else begin
            dev_lo     <= strap_meta[2:0];
            vec_base   <= strap_meta[4:3];
            strap_done <= 1'b1;
        end
    end

    // command decode while the cpu owns the bus
    function automatic pie_pkg::bus_cmd_t decode(
        input logic [`EBUS_W-1:0] w,
        input logic [2:0]         lo
    );
        pie_pkg::bus_cmd_t c;
        c.hit  = (w[`DEV_HI_LSB +: 3] == `DEV_HI) &&
                 (w[`DEV_LO_LSB +: 3] == lo); // [RULE_17]
        c.op   = w[`OP_LSB +: 3];
        c.func = w[`FUNC_LSB +: 3];
        return c;
    endfunction

    pie_pkg::bus_cmd_t cmd;
    pie_pkg::ctl_act_t act;
    assign cmd = decode(ebus_sync, dev_lo);
    always_comb begin
        act = '0;
        if (fry_rise && !ack_lvl && strap_done && cmd.hit) begin
            if (cmd.op == `OP_EXC) begin
                case (cmd.func)
                    `FN_CLEAR:   act.clear = 1'b1; // [RULE_15]
                    `FN_ENABLE:  act.enable = 1'b1; // [RULE_15]
                    `FN_CLR_EN: begin
                        act.clear  = 1'b1; // [RULE_15]
                        act.enable = 1'b1;
                    end
                    `FN_DISABLE: act.disarm = 1'b1; // [RULE_16]
                    `FN_CLR_DIS: begin
                        act.clear  = 1'b1; // [RULE_16]
                        act.disarm = 1'b1;
                    end
                    default: act = '0;
                endcase
            end else if (cmd.op == `OP_OUT) begin
                act.load = 1'b1;
            end
        end
    end

    // mask load: output command arms, data ready writes
    logic load_armed;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_armed <= 1'b0;
        end else if (act.load) begin
            load_armed <= 1'b1;
        end else if (dry_rise) begin
            load_armed <= 1'b0;
        end
    end

    // mask survives reset and never clears itself
    logic [NUM_LINES-1:0] line_disable_mask;
    always_ff @(posedge clk_i) begin
        if (load_armed && dry_rise) begin
            line_disable_mask <= ebus_sync[NUM_LINES-1:0]; // [RULE_07] [RULE_24]
        end
    end

    // scan timer
    logic [$clog2(SCAN_CYC)-1:0] scan_cnt;
    logic                        scan_tick;
    assign scan_tick = (scan_cnt == ($clog2(SCAN_CYC))'(SCAN_CYC - 1));
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scan_cnt <= '0;
        end else if (scan_tick) begin
            scan_cnt <= '0; // [RULE_03]
        end else begin
            scan_cnt <= scan_cnt + 1'b1;
        end
    end

    // line and sync registers, false-to-true detect
    logic [NUM_LINES-1:0] line_reg;
    logic [NUM_LINES-1:0] sync_reg;
    logic [NUM_LINES-1:0] new_req;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_reg <= '0;
            sync_reg <= '0;
        end else if (scan_tick) begin
            line_reg <= line_sync; // [RULE_02] [RULE_03]
            sync_reg <= line_reg; // [RULE_02]
        end
    end

    assign new_req = scan_tick ? (line_reg & ~sync_reg) : '0;

    // pending requests, set wins over clear
    logic [NUM_LINES-1:0] pending;
    logic [NUM_LINES-1:0] served;
    logic [NUM_LINES-1:0] next_pending;
    logic [NUM_LINES-1:0] eligible;
    always_comb begin
        next_pending = pending;
        if (act.clear) begin
            next_pending = '0;
        end
        next_pending = (next_pending & ~served) | new_req; // [RULE_05]
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending <= '0; // [RULE_24]
        end else begin
            pending <= next_pending;
        end
    end

    assign eligible = pending & ~line_disable_mask; // [RULE_06] [RULE_21]

    // bit 0 is the top priority line
    function automatic logic [2:0] top_level(
        input logic [NUM_LINES-1:0] v
    );
        logic [2:0] l;
        l = 3'h0;
        for (int i = NUM_LINES - 1; i >= 0; i--) begin
            if (v[i]) begin
                l = 3'(i); // [RULE_01] [RULE_04]
            end
        end
        return l;
    endfunction

    // enable flag
    logic request_enable_flag;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            request_enable_flag <= 1'b0; // [RULE_24]
        end else if (act.disarm || jmp_rise) begin
            request_enable_flag <= 1'b0; // [RULE_11] [RULE_23]
        end else if (act.enable) begin
            request_enable_flag <= 1'b1; // [RULE_23]
        end
    end

    // request sequencer
    pie_pkg::req_state_t state;
    pie_pkg::req_state_t next_state;
    logic [2:0]          level;
    logic                start_req;
    assign start_req = tclk_fall && request_enable_flag &&
                       chain_sync && (|eligible); // [RULE_18] [RULE_19]
    always_comb begin
        next_state = state;
        case (state)
            pie_pkg::ST_IDLE:
                if (start_req) begin
                    next_state = pie_pkg::ST_REQ;
                end
            pie_pkg::ST_REQ:
                if (ack_rise) begin
                    next_state = pie_pkg::ST_ACK;
                end
            pie_pkg::ST_ACK:
                if (ack_fall) begin
                    next_state = pie_pkg::ST_IDLE; // [RULE_20]
                end
            default: next_state = pie_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= pie_pkg::ST_IDLE; // [RULE_24]
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level <= 3'h0;
        end else if (state == pie_pkg::ST_IDLE && start_req) begin
            level <= top_level(eligible); // [RULE_04]
        end
    end

    // served line leaves pending at acknowledge
    always_comb begin
        served = '0;
        if (state == pie_pkg::ST_REQ && ack_rise) begin
            served[level] = 1'b1; // [RULE_05]
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_interrupt_request_o <= 1'b0;
            chain_priority_out_o    <= 1'b0;
        end else begin
            cpu_interrupt_request_o <=
                (next_state == pie_pkg::ST_REQ); // [RULE_19]
            chain_priority_out_o <= chain_sync &&
                (next_state == pie_pkg::ST_IDLE); // [RULE_22]
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ebus_o    <= 16'h0000;
            ebus_oe_o <= 1'b0;
        end else if (next_state == pie_pkg::ST_ACK) begin
            ebus_o    <= {9'h000, `VEC_TOP, vec_base,
                          level, 1'b0}; // [RULE_08] [RULE_09]
            ebus_oe_o <= 1'b1; // [RULE_20]
        end else begin
            ebus_o    <= 16'h0000;
            ebus_oe_o <= 1'b0; // [RULE_20]
        end
    end

endmodule

// file: pie_props.sv
// port checker for the priority interrupt expander
`timescale 1ns/1ns
`include "pie_map.svh"
module pie_props (
    input wire logic                clk_i,
    input wire logic                rst_n_i,
    input wire logic                interrupt_timing_clock_i,
    input wire logic                cpu_interrupt_acknowledge_i,
    input wire logic                chain_priority_in_i,
    input wire logic                cpu_interrupt_request_o,
    input wire logic                chain_priority_out_o,
    input wire logic [`EBUS_W-1:0]  ebus_o,
    input wire logic                ebus_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_req_blocks_chain: assert property (
        cpu_interrupt_request_o |-> !chain_priority_out_o)
        else $error("chain out high during request");
    a_req_trailing_edge: assert property (
        $rose(cpu_interrupt_request_o) |-> !$past(interrupt_timing_clock_i, 2))
        else $error("request not after trailing clock edge");
    a_req_chain_in: assert property (
        $rose(cpu_interrupt_request_o) |-> $past(chain_priority_in_i))
        else $error("request raised with chain in low");
    a_req_drops_ack: assert property (
        $rose(cpu_interrupt_acknowledge_i) |-> ##[1:6] !cpu_interrupt_request_o)
        else $error("request held after acknowledge");
    a_vec_range: assert property (
        ebus_oe_o |-> ebus_o[15:6] == 10'h001 && !ebus_o[0])
        else $error("vector outside range or odd");
    a_oe_on_ack: assert property (
        $rose(ebus_oe_o) |-> $past(cpu_interrupt_acknowledge_i, 2))
        else $error("vector driven without acknowledge");
    a_bus_release: assert property (
        $fell(cpu_interrupt_acknowledge_i) |-> ##[1:6] !ebus_oe_o)
        else $error("bus kept after acknowledge fell");
    a_idle_bus_zero: assert property (
        !ebus_oe_o |-> ebus_o == 16'h0000)
        else $error("bus value while not driving");
endmodule

// file: cpu_bus_model.sv
// cpu side model: interrupt clock, acknowledge, jump signal
`timescale 1ns/1ns
module cpu_bus_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic req_i,
    input  wire logic slow_i,
    input  wire logic jmp_en_i,
    output logic      tclk_o,
    output logic      ack_o,
    output logic      jmp_o
);
    logic [1:0] st;
    logic [5:0] cnt;
    logic [4:0] tcnt;
    // interrupt clock, held true while acknowledging
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tcnt <= 5'h00;
            tclk_o <= 1'b0;
        end else begin
            tcnt <= (tcnt == 5'h15) ? 5'h00 : tcnt + 5'h01;
            if (ack_o) tclk_o <= 1'b1;
            else if (tcnt == 5'h15) tclk_o <= ~tclk_o;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= 2'h0;
            cnt <= 6'h00;
            ack_o <= 1'b0;
            jmp_o <= 1'b0;
        end else begin
            jmp_o <= 1'b0;
            if (cnt != 6'h00) cnt <= cnt - 6'h01;
            else case (st)
                2'h0: if (req_i) begin
                    st <= 2'h1;
                    cnt <= slow_i ? 6'h28 : 6'h03;
                end
                2'h1: begin
                    ack_o <= 1'b1;
                    st <= 2'h2;
                    cnt <= 6'h0a;
                end
                2'h2: begin
                    jmp_o <= jmp_en_i;
                    st <= 2'h3;
                    cnt <= 6'h0a;
                end
                default: begin
                    ack_o <= 1'b0;
                    st <= 2'h0;
                    cnt <= 6'h08;
                end
            endcase
        end
    end
endmodule

// file: tb_top.sv
// self-checking testbench for the priority interrupt expander
`timescale 1ns/1ns
`include "pie_map.svh"
module tb_top;
    logic        clk_i = 0;
    logic        rst_n_i = 0;
    logic [7:0]  lines = 0;
    logic        fr = 0, dr = 0, chn = 1, slow = 0, jmp_en = 0;
    logic [15:0] eb = 0;
    logic [31:0] rnd = 32'h8293_71ec;
    logic [2:0]  strap;
    logic [1:0]  base;
    logic        tclk, ack, jmp, req, cho, oe, oe_d;
    logic [15:0] ebo;
    logic [15:0] seen[$];
    logic [2:0]  fns[3] = '{`FN_CLEAR, `FN_CLR_EN, `FN_CLR_DIS};
    logic [7:0]  v, m;
    int          err_total = 0, num_checks = 0, cyc = 0;
    always #10 clk_i = ~clk_i;
    priority_interrupt_expander #(.SCAN_CYC(5)) i_dut (
        .clk_i, .rst_n_i, .periph_line_i(lines),
        .interrupt_timing_clock_i(tclk), .cpu_interrupt_acknowledge_i(ack),
        .jump_mark_inhibit_i(jmp), .chain_priority_in_i(chn),
        .function_ready_i(fr), .data_ready_i(dr), .ebus_i(eb),
        .dev_addr_strap_i(strap), .vector_base_i(base),
        .cpu_interrupt_request_o(req), .chain_priority_out_o(cho),
        .ebus_o(ebo), .ebus_oe_o(oe));
    cpu_bus_model i_cpu (.clk_i, .rst_n_i, .req_i(req), .slow_i(slow),
        .jmp_en_i(jmp_en), .tclk_o(tclk), .ack_o(ack), .jmp_o(jmp));
    always @(posedge clk_i) begin
        oe_d <= oe;
        if (oe === 1'b1 && oe_d === 1'b0) seen.push_back(ebo);
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            results();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] vec(input int l);
        return {9'h000, `VEC_TOP, base, 3'(l), 1'b0};
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, s);
        num_checks++;
        if (e !== s) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            err_total++;
        end
    endtask
    task automatic strobe(input logic [15:0] w, input logic f);
        eb = w;
        step(4);
        if (f) fr = 1;
        else dr = 1;
        step(4);
        fr = 0;
        dr = 0;
        step(4);
        eb = ~w;
        step(1);
    endtask
    task automatic cmd(input logic [2:0] op, fn, dv);
        strobe({4'h0, op, fn, `DEV_HI, dv}, 1'b1);
    endtask
    task automatic mask_load(input logic [7:0] mk);
        cmd(`OP_OUT, 3'h1, strap);
        strobe({8'h00, mk}, 1'b0);
    endtask
    task automatic put(input logic [7:0] lv);
        lines = lv;
        step(30);
    endtask
    task automatic serve(input logic [7:0] exp);
        int n;
        n = $countones(exp);
        for (int k = 0; k < 3000 && seen.size() < n; k++) step(1);
        step(200);
        chk("count", 16'(n), 16'(seen.size()));
        for (int k = 0; k < 8; k++) begin
            if (exp[k]) begin
                chk("vector", vec(k), seen.size() ? seen.pop_front() : 0);
            end
        end
        seen.delete();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        strap = rnd[2:0];
        base = rnd[4:3];
        step(20);
        rst_n_i = 1;
        step(3);
        mask_load(8'h00);
        rnd = lfsr(rnd);
        v = rnd[7:0] | 8'h81;
        slow = rnd[8];
        put(v);
        cmd(`OP_EXC, `FN_ENABLE, strap);
        serve(v);
        put(0);
        $display("test order done");
        rnd = lfsr(rnd);
        m = rnd[15:8];
        v = rnd[7:0] | 8'h01;
        slow = rnd[16];
        cmd(`OP_EXC, `FN_DISABLE, strap);
        mask_load(m);
        put(v);
        cmd(`OP_EXC, `FN_ENABLE, strap);
        serve(v & ~m);
        mask_load(8'h00);
        serve(v & m);
        put(0);
        $display("test mask done");
        for (int i = 0; i < 3; i++) begin
            cmd(`OP_EXC, `FN_DISABLE, strap);
            put(8'h04);
            put(0);
            cmd(`OP_EXC, fns[i], strap);
            cmd(`OP_EXC, `FN_ENABLE, strap);
            serve(0);
        end
        cmd(`OP_EXC, `FN_DISABLE, strap);
        put(8'h10);
        put(0);
        cmd(`OP_EXC, `FN_ENABLE, strap + 3'h1);
        cmd(3'h5, `FN_ENABLE, strap);
        serve(0);
        cmd(`OP_EXC, `FN_ENABLE, strap);
        serve(8'h10);
        $display("test commands done");
        jmp_en = 1;
        put(8'h06);
        serve(8'h02);
        jmp_en = 0;
        cmd(`OP_EXC, `FN_ENABLE, strap);
        serve(8'h04);
        put(0);
        chn = 0;
        put(8'h08);
        serve(0);
        chk("chain out", 16'h0000, 16'(cho));
        chn = 1;
        serve(8'h08);
        chk("chain out", 16'h0001, 16'(cho));
        put(0);
        $display("test jump and chain done");
        mask_load(8'h01);
        cmd(`OP_EXC, `FN_DISABLE, strap);
        put(8'h04);
        put(0);
        rst_n_i = 0;
        step(2);
        rst_n_i = 1;
        step(3);
        cmd(`OP_EXC, `FN_ENABLE, strap);
        put(8'h03);
        serve(8'h02);
        mask_load(8'h00);
        serve(8'h01);
        $display("test reset done");
        results();
    end
endmodule
bind priority_interrupt_expander pie_props i_props (
    .clk_i, .rst_n_i, .interrupt_timing_clock_i,
    .cpu_interrupt_acknowledge_i, .chain_priority_in_i,
    .cpu_interrupt_request_o, .chain_priority_out_o, .ebus_o, .ebus_oe_o);
